// ### inc/cgv_pkg.sv
// Package for the channel-one gain, volume and calibration register group.
// Assumes one clock domain and the device's internal byte-wide control port.
package cgv_pkg;

    // ------------------------------------------------------------------
    // register offsets on the control port
    // ------------------------------------------------------------------
    localparam logic [7:0] CGV_OFS_GAIN   = 8'h3d;
    localparam logic [7:0] CGV_OFS_VOLUME = 8'h3e;
    localparam logic [7:0] CGV_OFS_TRIM   = 8'h3f;
    localparam logic [7:0] CGV_OFS_PHASE  = 8'h40;

    // ------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] CGV_RST_GAIN   = 8'h00;
    localparam logic [7:0] CGV_RST_VOLUME = 8'hc9;
    localparam logic [7:0] CGV_RST_TRIM   = 8'h80;
    localparam logic [7:0] CGV_RST_PHASE  = 8'h00;

    // ------------------------------------------------------------------
    // field layout and code points
    // ------------------------------------------------------------------
    localparam int         CGV_GAIN_CODE_LSB = 1;
    localparam int         CGV_GAIN_SIGN_BIT = 0;
    localparam int         CGV_TRIM_CODE_LSB = 4;
    localparam logic [7:0] CGV_TRIM_WR_MASK  = 8'hf0;
    localparam logic [6:0] CGV_GAIN_CODE_MAX = 7'h54;
    localparam logic [6:0] CGV_NEG_GAIN_MAX  = 7'h16;
    localparam logic [8:0] CGV_VOL_UNITY     = 9'h0c9;
    localparam logic [4:0] CGV_TRIM_ZERO     = 5'h08;
    localparam logic [7:0] CGV_VOL_MUTE      = 8'h00;
    localparam int         CGV_DELAY_DEPTH   = 256;

    // input impedance setting of the channel
    typedef enum logic [1:0] {
        CGV_IMP_2K5,
        CGV_IMP_10K,
        CGV_IMP_20K,
        CGV_IMP_RSVD
    } cgv_imp_e;

    // decoded settings handed to the channel datapath
    typedef struct packed {
        logic signed [7:0] gain_half_db;   // analog gain, 0.5 dB units
        logic signed [8:0] volume_half_db; // digital volume, 0.5 dB units
        logic              mute;           // digital output muted
        logic signed [4:0] trim_tenth_db;  // gain trim, 0.1 dB units
        logic        [7:0] delay_cycles;   // phase delay, modulator cycles
        logic              gain_code_bad;  // reserved gain code written
        logic              neg_gain_bad;   // negative gain at 2.5 k or reserved input
    } cgv_settings_s;

endpackage

// ### rtl/cgv_ch1_regs.sv
// Channel-one gain, digital volume, gain trim and phase delay registers,
// with their decoded settings and the modulator-rate phase delay line.
// Assumes the control-port bridge presents single-cycle byte accesses on clk
// and a modulator-rate enable pulse from the clock divider.
`timescale 1ns/1ps
// Behaviour
// - the gain code in bits 7..1 counts half-decibel steps from 0 dB up to 42 dB at code 84.
// - with bit 0 of the gain register set the gain is negative, no lower than -11 dB.
// - volume code zero mutes the channel output completely.
// - nonzero volume codes count half-decibel steps from -100 dB at code 1 to +27 dB at 255.
// - the volume register resets to 201, which is 0 dB, and 202 is +0.5 dB.
// - the trim code in bits 7..4 counts 0.1 dB steps, -0.8 dB at 0, 0 dB at 8, +0.7 dB at 15.
// - bits 3..0 of the trim register are read-only zero and the host writes them as zero.
// - the channel is delayed by the phase code in modulator cycles, 0 to 255.
// - gain, trim and phase registers reset to 00, 80 and 00.
// - the impedance setting reads 0 as 2.5 k, 1 as 10 k, 2 as 20 k and 3 as reserved.
module cgv_ch1_regs
    import cgv_pkg::*;
(
    input  wire logic          clk,
    input  wire logic          sys_rst,
    input  wire logic [7:0]    reg_addr,
    input  wire logic          reg_wr_en,
    input  wire logic [7:0]    reg_wr_data,
    input  wire logic          reg_rd_en,
    output logic      [7:0]    reg_rd_data,
    output logic               reg_rd_hit,
    input  wire logic [1:0]    chan_one_input_impedance_sel,
    input  wire logic          mod_clk_en,
    input  wire logic          mod_bit_in,
    output logic               mod_bit_out,
    output cgv_settings_s      settings
);

    // ------------------------------------------------------------------
    // register storage
    // ------------------------------------------------------------------
    logic [7:0]    gain_reg,   gain_next;
    logic [7:0]    volume_reg, volume_next;
    logic [7:0]    trim_reg,   trim_next;
    logic [7:0]    phase_reg,  phase_next;
    logic [7:0]    rd_data_reg, rd_data_next;
    logic          rd_hit_reg,  rd_hit_next;

    // maps an offset to its stored value; unmapped offsets miss
    function automatic logic [8:0] cgv_read_mux(input logic [7:0] addr, input logic [7:0] g,
                                                input logic [7:0] v, input logic [7:0] t,
                                                input logic [7:0] p);
        logic [8:0] r;
        r = 9'h000;
        unique case (addr)
            CGV_OFS_GAIN:   r = {1'b1, g};
            CGV_OFS_VOLUME: r = {1'b1, v};
            CGV_OFS_TRIM:   r = {1'b1, t};
            CGV_OFS_PHASE:  r = {1'b1, p};
            default:        r = 9'h000;
        endcase
        return r;
    endfunction

    // write decode and read capture
    always_comb begin
        logic [8:0] rd;
        rd           = cgv_read_mux(reg_addr, gain_reg, volume_reg, trim_reg, phase_reg);
        gain_next    = gain_reg;
        volume_next  = volume_reg;
        trim_next    = trim_reg;
        phase_next   = phase_reg;
        rd_data_next = rd_data_reg;
        rd_hit_next  = 1'b0;
        if (reg_wr_en) begin
            unique case (reg_addr)
                CGV_OFS_GAIN:   gain_next   = reg_wr_data;
                CGV_OFS_VOLUME: volume_next = reg_wr_data;
                CGV_OFS_TRIM:   trim_next   = reg_wr_data & CGV_TRIM_WR_MASK;
                CGV_OFS_PHASE:  phase_next  = reg_wr_data;
                default:        ;
            endcase
        end
        if (reg_rd_en) begin
            rd_data_next = rd[7:0]; // unmapped offsets read zero
            rd_hit_next  = rd[8];
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            gain_reg    <= CGV_RST_GAIN;
            volume_reg  <= CGV_RST_VOLUME;
            trim_reg    <= CGV_RST_TRIM;
            phase_reg   <= CGV_RST_PHASE;
            rd_data_reg <= 8'h00;
            rd_hit_reg  <= 1'b0;
        end else begin
            gain_reg    <= gain_next;
            volume_reg  <= volume_next;
            trim_reg    <= trim_next;
            phase_reg   <= phase_next;
            rd_data_reg <= rd_data_next;
            rd_hit_reg  <= rd_hit_next;
        end
    end

    assign reg_rd_data = rd_data_reg;
    assign reg_rd_hit  = rd_hit_reg;

    // ------------------------------------------------------------------
    // decoded settings
    // ------------------------------------------------------------------
    cgv_settings_s settings_reg, settings_next;
    cgv_imp_e      imp_sel;

    assign imp_sel = cgv_imp_e'(chan_one_input_impedance_sel);

    always_comb begin
        logic [6:0] gcode;
        logic [6:0] mag;
        logic       neg;
        gcode = gain_reg[7:CGV_GAIN_CODE_LSB];
        neg   = gain_reg[CGV_GAIN_SIGN_BIT];
        // reserved codes clamp to 42 dB
        mag = (gcode > CGV_GAIN_CODE_MAX) ? CGV_GAIN_CODE_MAX : gcode;
        if (neg && mag > CGV_NEG_GAIN_MAX) begin
            mag = CGV_NEG_GAIN_MAX;
        end
        settings_next.gain_half_db = neg ? -$signed({1'b0, mag}) : $signed({1'b0, mag});
        settings_next.volume_half_db = $signed({1'b0, volume_reg}) - $signed(CGV_VOL_UNITY);
        settings_next.mute = (volume_reg == CGV_VOL_MUTE);
        settings_next.trim_tenth_db = $signed({1'b0, trim_reg[7:CGV_TRIM_CODE_LSB]})
                                      - $signed(CGV_TRIM_ZERO);
        // delay count straight from the field
        settings_next.delay_cycles  = phase_reg;
        settings_next.gain_code_bad = (gcode > CGV_GAIN_CODE_MAX);
        // negative gain needs 10 k or 20 k input
        settings_next.neg_gain_bad  = neg && (imp_sel == CGV_IMP_2K5 || imp_sel == CGV_IMP_RSVD);
    end

    // settings registered so the datapath sees glitch-free values
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            settings_reg <= '0;
        end else begin
            settings_reg <= settings_next;
        end
    end

    assign settings = settings_reg;

    // ------------------------------------------------------------------
    // phase delay line at modulator rate
    // ------------------------------------------------------------------
    logic [CGV_DELAY_DEPTH-1:0] delay_reg, delay_next;
    logic                       mod_out_reg, mod_out_next;

    // a tap select keeps one shift chain; changing the code mid-stream
    // jumps the tap, so expect a short glitch on reprogramming
    always_comb begin
        delay_next   = delay_reg;
        mod_out_next = mod_out_reg;
        if (mod_clk_en) begin
            delay_next = {delay_reg[CGV_DELAY_DEPTH-2:0], mod_bit_in};
            if (phase_reg == 8'h00) begin
                mod_out_next = mod_bit_in;
            end else begin
                mod_out_next = delay_reg[phase_reg - 8'h01];
            end
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            delay_reg   <= '0;
            mod_out_reg <= 1'b0;
        end else begin
            delay_reg   <= delay_next;
            mod_out_reg <= mod_out_next;
        end
    end

    assign mod_bit_out = mod_out_reg;

endmodule // cgv_ch1_regs

// ### test/cgv_ch1_monitor.sv
// checker for the channel-one gain, volume, trim and phase registers
// sees only the top ports; bound to the register block below
`timescale 1ns/1ps
module cgv_ch1_monitor import cgv_pkg::*; (
    input wire logic          clk,
    input wire logic          sys_rst,
    input wire logic [7:0]    reg_addr,
    input wire logic          reg_wr_en,
    input wire logic [7:0]    reg_wr_data,
    input wire logic          reg_rd_en,
    input wire logic [7:0]    reg_rd_data,
    input wire logic          reg_rd_hit,
    input wire logic [1:0]    chan_one_input_impedance_sel,
    input wire logic          mod_clk_en,
    input wire logic          mod_bit_in,
    input wire logic          mod_bit_out,
    input wire cgv_settings_s settings
);
    // ------------------------------------------------------------
    // write decodes; settings lag the store by one edge
    // ------------------------------------------------------------
    logic wg, wv, wt, wp;
    assign wg = reg_wr_en && reg_addr == CGV_OFS_GAIN;
    assign wv = reg_wr_en && reg_addr == CGV_OFS_VOLUME;
    assign wt = reg_wr_en && reg_addr == CGV_OFS_TRIM;
    assign wp = reg_wr_en && reg_addr == CGV_OFS_PHASE;
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    a_gain_pos: assert property (wg && !reg_wr_data[0] && reg_wr_data[7:1] <= 7'd84
        |=> ##1 settings.gain_half_db == $signed({1'b0, $past(reg_wr_data[7:1], 2)})) else $error("gain decode");
    a_gain_neg: assert property (wg && reg_wr_data[0] && reg_wr_data[7:1] <= 7'd22
        |=> ##1 settings.gain_half_db == -$signed({1'b0, $past(reg_wr_data[7:1], 2)})) else $error("neg gain");
    a_vol_step: assert property (wv && reg_wr_data != 8'h00 |=> ##1 !settings.mute
        && settings.volume_half_db == $signed({1'b0, $past(reg_wr_data, 2)}) - 9'sd201) else $error("volume");
    a_vol_mute: assert property (wv && reg_wr_data == 8'h00 |=> ##1 settings.mute) else $error("mute");
    a_trim_step: assert property (wt
        |=> ##1 settings.trim_tenth_db == $signed({1'b0, $past(reg_wr_data[7:4], 2)}) - 5'sd8) else $error("trim");
    a_phase_code: assert property (wp |=> ##1 settings.delay_cycles == $past(reg_wr_data, 2)) else $error("phase");
    a_trim_low: assert property (reg_rd_en && reg_addr == CGV_OFS_TRIM
        |=> reg_rd_hit && reg_rd_data[3:0] == 4'h0) else $error("trim low bits");
    a_unmapped_rd: assert property (reg_rd_en && !(reg_addr inside {[8'h3d:8'h40]})
        |=> !reg_rd_hit && reg_rd_data == 8'h00) else $error("unmapped read");
    a_tap_zero: assert property (mod_clk_en && settings.delay_cycles == 8'h00 && !wp && !$past(wp)
        |=> mod_bit_out == $past(mod_bit_in)) else $error("zero delay tap");
endmodule // cgv_ch1_monitor
bind cgv_ch1_regs cgv_ch1_monitor mon (
    .clk                          (clk),
    .sys_rst                      (sys_rst),
    .reg_addr                     (reg_addr),
    .reg_wr_en                    (reg_wr_en),
    .reg_wr_data                  (reg_wr_data),
    .reg_rd_en                    (reg_rd_en),
    .reg_rd_data                  (reg_rd_data),
    .reg_rd_hit                   (reg_rd_hit),
    .chan_one_input_impedance_sel (chan_one_input_impedance_sel),
    .mod_clk_en                   (mod_clk_en),
    .mod_bit_in                   (mod_bit_in),
    .mod_bit_out                  (mod_bit_out),
    .settings                     (settings)
);

// ### test/cgv_host_model.sv
// host model of the byte-wide configuration port
// requests change just after a falling edge and last one cycle
`timescale 1ns/1ps
module cgv_host_model import cgv_pkg::*; (
    input  wire logic       clk,
    input  wire logic [7:0] reg_rd_data,
    input  wire logic       reg_rd_hit,
    output logic      [7:0] reg_addr,
    output logic            reg_wr_en,
    output logic      [7:0] reg_wr_data,
    output logic            reg_rd_en,
    output logic      [1:0] chan_one_input_impedance_sel
);
    // idle port at time zero
    initial begin
        {reg_addr, reg_wr_data, reg_wr_en, reg_rd_en} = '0;
        chan_one_input_impedance_sel = 2'd0;
    end
    task automatic wr(input logic [7:0] a, d);
        if (a == CGV_OFS_GAIN && d[7:1] > CGV_GAIN_CODE_MAX) d[7:1] = CGV_GAIN_CODE_MAX;
        if (a == CGV_OFS_GAIN && d[0]) chan_one_input_impedance_sel = 2'd2;
        if (a == CGV_OFS_TRIM) d[3:0] = 4'h0;
        @(negedge clk);
        {reg_addr, reg_wr_data, reg_wr_en} = {a, d, 1'b1};
        @(negedge clk);
        reg_wr_en = 1'b0;
    endtask
    // data sampled at the falling edge after the answering edge
    task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic h);
        @(negedge clk);
        {reg_addr, reg_rd_en} = {a, 1'b1};
        @(negedge clk);
        reg_rd_en = 1'b0;
        {d, h} = {reg_rd_data, reg_rd_hit};
    endtask
endmodule // cgv_host_model

// ### test/tb_top.sv
// testbench for the channel-one register group
// host model drives the register port; bench drives the modulator side
`timescale 1ns/1ps
module tb_top import cgv_pkg::*; ;
    logic clk, sys_rst, reg_wr_en, reg_rd_en, reg_rd_hit, mod_clk_en, mod_bit_in, mod_bit_out;
    logic [7:0] reg_addr, reg_wr_data, reg_rd_data;
    logic [1:0] chan_one_input_impedance_sel;
    cgv_settings_s settings;
    int fails = 0, samples_checked = 0;
    cgv_ch1_regs uut (.*);
    cgv_host_model host (.*);
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    task automatic chk(input logic [31:0] g, e);
        samples_checked++;
        if (g !== e) begin
            fails++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic rchk(input logic [7:0] a, e);
        logic [7:0] d;
        logic h;
        host.rd(a, d, h);
        chk(d, e);
        chk(h, a inside {[8'h3d:8'h40]});
    endtask
    // write, let the settings settle one edge, compare the decoded field
    task automatic wf(input logic [7:0] a, d, input logic [31:0] e);
        logic [31:0] g;
        host.wr(a, d);
        @(negedge clk);
        case (a)
            CGV_OFS_GAIN: g = $signed(settings.gain_half_db);
            CGV_OFS_VOLUME: g = $signed(settings.volume_half_db);
            CGV_OFS_TRIM: g = $signed(settings.trim_tenth_db);
            default: g = settings.delay_cycles;
        endcase
        chk(g, e);
        // host keeps legal gain codes and impedance, so neither flag may rise
        if (a == CGV_OFS_GAIN) chk({settings.gain_code_bad, settings.neg_gain_bad}, 0);
    endtask
    task automatic t_reset;
        rchk(8'h3d, 8'h00);
        rchk(8'h3e, 8'hc9);
        rchk(8'h3f, 8'h80);
        rchk(8'h40, 8'h00);
        rchk(8'h41, 8'h00);
        chk(settings.mute, 0);
    endtask
    task automatic t_gain;
        wf(8'h3d, 8'h02, 1);
        wf(8'h3d, 8'h3c, 30);
        wf(8'h3d, 8'ha8, 84);
        wf(8'h3d, 8'h2b, -21);
        wf(8'h3d, 8'h51, -22);
        wf(8'h3d, 8'h00, 0);
    endtask
    task automatic t_volume;
        wf(8'h3e, 8'h00, -201);
        chk(settings.mute, 1);
        wf(8'h3e, 8'h01, -200);
        chk(settings.mute, 0);
        wf(8'h3e, 8'h02, -199);
        wf(8'h3e, 8'hca, 1);
        wf(8'h3e, 8'hff, 54);
    endtask
    task automatic t_trim;
        wf(8'h3f, 8'h00, -8);
        wf(8'h3f, 8'hf0, 7);
        wf(8'h3f, 8'h50, -3);
        rchk(8'h3f, 8'h50);
    endtask
    // enables every other cycle; early outputs hold older bits
    task automatic t_phase(input logic [7:0] n);
        logic [15:0] b;
        b = 16'hb4e1;
        wf(8'h40, n, n);
        for (int k = 0; k < 16; k++) begin
            {mod_clk_en, mod_bit_in} = {1'b1, b[k]};
            @(negedge clk);
            mod_clk_en = 1'b0;
            if (k >= n) chk(mod_bit_out, b[k-n]);
            @(negedge clk);
        end
    endtask
    // end phase code, then a mid-run reset must bring back every reset value
    task automatic t_rerun;
        wf(8'h40, 8'hff, 255);
        host.wr(8'h3e, 8'h10);
        @(negedge clk);
        sys_rst = 1'b1;
        repeat (2) @(negedge clk);
        chk(settings, 0);
        chk(mod_bit_out, 0);
        sys_rst = 1'b0;
        t_reset();
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    initial begin
        {sys_rst, mod_clk_en, mod_bit_in} = 3'b100;
        repeat (16) @(negedge clk);
        sys_rst = 1'b0;
        t_reset();
        t_gain();
        t_volume();
        t_trim();
        t_phase(8'h03);
        t_phase(8'h00);
        t_rerun();
        results();
    end
    // hang guard, far beyond the roughly 160 cycles the run needs
    initial begin
        #20000;
        fails++;
        results();
    end
endmodule // tb_top
